/* File: design/qpi_slave.sv */
// Two-wire slave holding four wiper registers and the shutdown control register.
`timescale 1ns/1ps
module qpi_slave (
  input wire logic clock,
  input wire logic srst,
  qpi_bus_if.slave bus,
  input wire logic [2:0] addr_select,
  output logic [7:0] wiper_position_reg [qpi_pkg::QPI_NUM_WIPERS],
  output logic shutdown_n_bit,
  output logic busy
);
  import qpi_pkg::*;

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_prev;
    logic sda_prev;
    logic [3:0] pwr_cnt;
    qpi_slave_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] reg_addr;
    logic rd_dir;
    logic sda_drive_low;
    logic [3:0][7:0] wiper;
    logic [7:0] ctrl;
    logic [1:0][2:0] sel_sync;
  } qpi_slave_st_t;

  qpi_slave_st_t st;
  qpi_slave_st_t next_st;

  function automatic logic [7:0] qpi_read_reg(input qpi_slave_st_t s, input logic [7:0] a);
    if (a < 8'(QPI_NUM_WIPERS)) begin
      return s.wiper[a[1:0]];
    end else if (a == QPI_CTRL_ADDR) begin
      return s.ctrl & QPI_CTRL_MASK;
    end
    return 8'h00;
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic [7:0] byte_in;
    logic [7:0] rd_byte;
    scl_s = st.scl_sync[1];
    sda_s = st.sda_sync[1];
    rd_byte = qpi_read_reg(st, st.reg_addr);
    next_st = st;
    next_st.scl_sync = {st.scl_sync[0], bus.scl};
    // The select pins are straps, but they still pass two flops so a moving pin cannot upset the id match.
    next_st.sel_sync = {st.sel_sync[0], addr_select};
    next_st.sda_sync = {st.sda_sync[0], bus.sda};
    next_st.scl_prev = scl_s;
    next_st.sda_prev = sda_s;
    scl_rise = scl_s && !st.scl_prev;
    scl_fall = !scl_s && st.scl_prev;
    start_c = scl_s && st.scl_prev && st.sda_prev && !sda_s;
    stop_c = scl_s && st.scl_prev && !st.sda_prev && sda_s;
    byte_in = {st.shift[6:0], sda_s};
    if (st.pwr_cnt != 4'h0) begin
      next_st.pwr_cnt = st.pwr_cnt - 4'h1;
    end else if (start_c) begin
      next_st.state = QPI_S_ID;
      next_st.bit_cnt = 4'h0;
      next_st.sda_drive_low = 1'b0;
    end else if (stop_c) begin
      next_st.state = QPI_S_IDLE;
      next_st.sda_drive_low = 1'b0;
    end else if (scl_rise) begin
      case (st.state)
        QPI_S_ID, QPI_S_ADDR, QPI_S_WDATA: begin
          next_st.shift = byte_in;
          next_st.bit_cnt = st.bit_cnt + 4'h1;
        end
        QPI_S_RDATA_ACK: begin
          if (sda_s) begin
            next_st.state = QPI_S_IDLE;
          end
        end
        default: begin
          next_st.state = st.state;
        end
      endcase
    end else if (scl_fall) begin
      case (st.state)
        QPI_S_ID: begin
          if (st.bit_cnt == 4'h8) begin
            if (st.shift[7:4] == QPI_ID_PREFIX && st.shift[3:1] == st.sel_sync[1]) begin
              next_st.state = QPI_S_ID_ACK;
              next_st.rd_dir = st.shift[0];
              next_st.sda_drive_low = 1'b1;
            end else begin
              next_st.state = QPI_S_IDLE;
            end
          end
        end
        QPI_S_ID_ACK: begin
          next_st.bit_cnt = 4'h0;
          if (st.rd_dir) begin
            next_st.state = QPI_S_RDATA;
            next_st.shift = rd_byte;
            next_st.sda_drive_low = !rd_byte[7];
          end else begin
            next_st.state = QPI_S_ADDR;
            next_st.sda_drive_low = 1'b0;
          end
        end
        QPI_S_ADDR: begin
          if (st.bit_cnt == 4'h8) begin
            next_st.reg_addr = st.shift;
            next_st.state = QPI_S_ADDR_ACK;
            next_st.sda_drive_low = 1'b1;
          end
        end
        QPI_S_WDATA: begin
          if (st.bit_cnt == 4'h8) begin
            next_st.state = QPI_S_WDATA_ACK;
            next_st.sda_drive_low = 1'b1;
            if (st.reg_addr < 8'(QPI_NUM_WIPERS)) begin
              next_st.wiper[st.reg_addr[1:0]] = st.shift;
            end else if (st.reg_addr == QPI_CTRL_ADDR) begin
              next_st.ctrl = st.shift & QPI_CTRL_MASK;
            end
            next_st.reg_addr = st.reg_addr + 8'h01;
          end
        end
        QPI_S_ADDR_ACK, QPI_S_WDATA_ACK: begin
          next_st.state = QPI_S_WDATA;
          next_st.bit_cnt = 4'h0;
          next_st.sda_drive_low = 1'b0;
        end
        QPI_S_RDATA: begin
          if (st.bit_cnt == 4'h7) begin
            next_st.state = QPI_S_RDATA_ACK;
            next_st.sda_drive_low = 1'b0;
            next_st.reg_addr = st.reg_addr + 8'h01;
          end else begin
            next_st.bit_cnt = st.bit_cnt + 4'h1;
            next_st.shift = {st.shift[6:0], 1'b0};
            next_st.sda_drive_low = !st.shift[6];
          end
        end
        QPI_S_RDATA_ACK: begin
          next_st.state = QPI_S_RDATA;
          next_st.bit_cnt = 4'h0;
          next_st.shift = rd_byte;
          next_st.sda_drive_low = !rd_byte[7];
        end
        default: begin
          next_st.state = st.state;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clock) begin
    if (srst) begin
      st <= '0;
      st.scl_sync <= 2'b11;
      st.sda_sync <= 2'b11;
      st.scl_prev <= 1'b1;
      st.sda_prev <= 1'b1;
      st.pwr_cnt <= QPI_POWERUP_CYCLES;
      st.state <= QPI_S_IDLE;
      st.wiper <= {QPI_NUM_WIPERS{QPI_WIPER_RESET}};
      st.ctrl <= QPI_CTRL_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  always_comb begin
    for (int i = 0; i < QPI_NUM_WIPERS; i++) begin
      wiper_position_reg[i] = st.wiper[i];
    end
  end
  assign shutdown_n_bit = st.ctrl[QPI_SHUTDOWN_POS];
  assign busy = (st.state != QPI_S_IDLE);
  assign bus.s_sda_out = 1'b0;
  assign bus.s_sda_oe_n = !st.sda_drive_low;
endmodule

/* File: design/qpi_pkg.sv */
// Package of constants and types shared by the potentiometer serial slave and its bus master.
// Behaviour
// - Data changes only while clock low.
// - Slave data pin released after power-up.
// - Slave ignores traffic until a START.
// - START during power-up is disregarded.
// - STOP ends transfer, slave returns standby.
// - Receiver pulls data low on ninth clock.
// - Slave acknowledges valid id, address, write data.
// - Master acknowledges read bytes except last.
// - Id is 1010, select pins, direction bit.
// - Write is id, address, data, STOP.
// - Data committed on ninth clock of byte; the slave commits it on the falling edge of the eighth clock.
// - Further data bytes load following channels.
// - Read uses write id, address, restart, read id.
// - Master ends read with NACK then STOP.
// - Bytes shift most significant bit first.
// - Wipers 0-3 reset 80h, control 10h resets 40h.
// - Control bit 6 is active-low shutdown.
package qpi_pkg;
  localparam logic [3:0] QPI_ID_PREFIX = 4'ha;
  localparam logic [7:0] QPI_WIPER_RESET = 8'h80;
  localparam logic [7:0] QPI_CTRL_ADDR = 8'h10;
  localparam logic [7:0] QPI_CTRL_RESET = 8'h40;
  localparam int QPI_SHUTDOWN_POS = 6;
  localparam logic [7:0] QPI_CTRL_MASK = 8'h40;
  localparam int QPI_NUM_WIPERS = 4;
  // Power-up hold time in clock cycles before START is honoured.
  localparam logic [3:0] QPI_POWERUP_CYCLES = 4'h8;
  // Master divider reload: each quarter of a serial clock period lasts this value plus one clock cycles.
  // The slave needs at least four cycles per quarter, since it sees every line three cycles late.
  localparam logic [7:0] QPI_HALF_PERIOD = 8'h04;

  typedef enum logic [3:0] {
    QPI_S_IDLE = 4'h0,
    QPI_S_ID = 4'h1,
    QPI_S_ID_ACK = 4'h2,
    QPI_S_ADDR = 4'h3,
    QPI_S_ADDR_ACK = 4'h4,
    QPI_S_WDATA = 4'h5,
    QPI_S_WDATA_ACK = 4'h6,
    QPI_S_RDATA = 4'h7,
    QPI_S_RDATA_ACK = 4'h8
  } qpi_slave_state_t;

  typedef enum logic [3:0] {
    QPI_M_IDLE = 4'h0,
    QPI_M_START = 4'h1,
    QPI_M_BIT = 4'h2,
    QPI_M_ACK = 4'h3,
    QPI_M_STOP = 4'h4,
    QPI_M_DONE = 4'h5
  } qpi_master_state_t;
endpackage

/* File: design/qpi_bus_if.sv */
// Interface joining the potentiometer slave and its bus master over the two-wire bus.
`timescale 1ns/1ps
interface qpi_bus_if;
  logic scl_out;
  logic scl_oe_n;
  logic m_sda_out;
  logic m_sda_oe_n;
  logic s_sda_out;
  logic s_sda_oe_n;
  logic scl;
  logic sda;
  // Open drain with pull-ups: a line is low only when a party drives it low.
  assign scl = (scl_oe_n == 1'b0) ? scl_out : 1'b1;
  assign sda = ((m_sda_oe_n == 1'b0) && (m_sda_out == 1'b0)) ? 1'b0 :
               ((s_sda_oe_n == 1'b0) && (s_sda_out == 1'b0)) ? 1'b0 : 1'b1;
  modport slave (input scl, input sda, output s_sda_out, output s_sda_oe_n);
  modport master (input scl, input sda, output scl_out, output scl_oe_n, output m_sda_out, output m_sda_oe_n);
endinterface

/* File: design/qpi_master.sv */
// Two-wire bus master that performs register writes and reads on the potentiometer slave.
`timescale 1ns/1ps
module qpi_master (
  input wire logic clock,
  input wire logic srst,
  qpi_bus_if.master bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [2:0] cmd_dev,
  input wire logic [7:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  output logic [7:0] rsp_rdata,
  output logic rsp_valid,
  output logic rsp_nack
);
  import qpi_pkg::*;

  typedef struct packed {
    logic [1:0] sda_sync;
    logic [7:0] div;
    logic [1:0] phase;
    qpi_master_state_t state;
    logic [1:0] byte_idx;
    logic [2:0] bit_idx;
    logic [7:0] shift;
    logic rd;
    logic [2:0] dev;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic scl_low;
    logic sda_low;
    logic nack;
    logic [7:0] rdata;
    logic done;
  } qpi_master_st_t;

  qpi_master_st_t st;
  qpi_master_st_t next_st;

  function automatic logic [7:0] qpi_byte(input qpi_master_st_t s, input logic [1:0] idx);
    case (idx)
      2'h0: return {QPI_ID_PREFIX, s.dev, 1'b0};
      2'h1: return s.addr;
      2'h2: return s.rd ? {QPI_ID_PREFIX, s.dev, 1'b1} : s.wdata;
      default: return 8'hff;
    endcase
  endfunction

  // ==========================================================
  // Next state; each tick is a quarter of a serial clock period.
  always_comb begin
    logic tick;
    logic receiving;
    tick = (st.div == 8'h00);
    receiving = st.rd && (st.byte_idx == 2'h3);
    next_st = st;
    next_st.sda_sync = {st.sda_sync[0], bus.sda};
    next_st.done = 1'b0;
    next_st.div = tick ? QPI_HALF_PERIOD : st.div - 8'h01;
    case (st.state)
      QPI_M_IDLE: begin
        if (cmd_valid) begin
          next_st.state = QPI_M_START;
          next_st.rd = cmd_read;
          next_st.dev = cmd_dev;
          next_st.addr = cmd_addr;
          next_st.wdata = cmd_wdata;
          next_st.byte_idx = 2'h0;
          next_st.nack = 1'b0;
          next_st.phase = 2'h0;
        end
      end
      QPI_M_START: begin
        if (tick) begin
          next_st.phase = st.phase + 2'h1;
          case (st.phase)
            2'h0: begin
              next_st.sda_low = 1'b0;
              next_st.scl_low = 1'b0;
            end
            2'h1: next_st.sda_low = 1'b1;
            2'h2: next_st.scl_low = 1'b1;
            default: begin
              next_st.state = QPI_M_BIT;
              next_st.bit_idx = 3'h7;
              next_st.shift = qpi_byte(st, st.byte_idx);
            end
          endcase
        end
      end
      QPI_M_BIT, QPI_M_ACK: begin
        if (tick) begin
          next_st.phase = st.phase + 2'h1;
          case (st.phase)
            2'h0: begin
              if (st.state == QPI_M_ACK) begin
                next_st.sda_low = receiving && !(st.byte_idx == 2'h3);
              end else begin
                next_st.sda_low = receiving ? 1'b0 : !st.shift[7];
              end
            end
            2'h1: next_st.scl_low = 1'b0;
            2'h2: begin
              if (st.state == QPI_M_BIT) begin
                next_st.rdata = {st.rdata[6:0], st.sda_sync[1]};
              end else if (!receiving && st.sda_sync[1]) begin
                next_st.nack = 1'b1;
              end
            end
            default: begin
              next_st.scl_low = 1'b1;
              if (st.state == QPI_M_BIT) begin
                next_st.shift = {st.shift[6:0], 1'b0};
                if (st.bit_idx == 3'h0) begin
                  next_st.state = QPI_M_ACK;
                end else begin
                  next_st.bit_idx = st.bit_idx - 3'h1;
                end
              end else if (st.nack || receiving || (st.byte_idx == 2'h2 && !st.rd)) begin
                next_st.state = QPI_M_STOP;
              end else if (st.rd && st.byte_idx == 2'h1) begin
                next_st.byte_idx = 2'h2;
                next_st.state = QPI_M_START;
                next_st.sda_low = 1'b0;
              end else begin
                next_st.byte_idx = st.byte_idx + 2'h1;
                next_st.state = QPI_M_BIT;
                next_st.bit_idx = 3'h7;
                next_st.shift = qpi_byte(st, st.byte_idx + 2'h1);
              end
            end
          endcase
        end
      end
      QPI_M_STOP: begin
        if (tick) begin
          next_st.phase = st.phase + 2'h1;
          case (st.phase)
            2'h0: next_st.sda_low = 1'b1;
            2'h1: next_st.scl_low = 1'b0;
            2'h2: next_st.sda_low = 1'b0;
            default: next_st.state = QPI_M_DONE;
          endcase
        end
      end
      QPI_M_DONE: begin
        next_st.done = 1'b1;
        next_st.state = QPI_M_IDLE;
      end
      default: next_st.state = QPI_M_IDLE;
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge clock) begin
    if (srst) begin
      st <= '0;
      st.sda_sync <= 2'b11;
      st.state <= QPI_M_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign cmd_ready = (st.state == QPI_M_IDLE);
  assign rsp_rdata = st.rdata;
  assign rsp_valid = st.done;
  assign rsp_nack = st.nack;
  assign bus.scl_out = 1'b0;
  assign bus.scl_oe_n = !st.scl_low;
  assign bus.m_sda_out = 1'b0;
  assign bus.m_sda_oe_n = !st.sda_low;
endmodule

/* File: verification/qpi_link_asserts.sv */
// Concurrent checks on the two-wire link between the slave and its master.
`timescale 1ns/1ps
module qpi_link_asserts (
  input wire logic clock,
  input wire logic srst,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_oe_n,
  input wire logic m_sda_oe_n,
  input wire logic s_sda_oe_n,
  input wire logic [2:0] addr_select
);
  import qpi_pkg::*;
  typedef struct packed {
    logic [3:0] cnt;
    logic [7:0] sh;
    logic first;
    logic rd;
    logic seen;
    logic p_scl;
    logic p_sda;
  } qpi_chk_t;
  qpi_chk_t st;
  qpi_chk_t next_st;
  logic hi;
  // ==========================================================================
  // Bit slot tracking
  // The ack bit is kept out of the shifter so the ninth slot still sees the whole byte.
  always_comb begin
    next_st = st;
    if (srst) begin
      next_st = '0;
    end else if (st.p_scl && scl && st.p_sda && !sda) begin
      next_st.cnt = 4'h0;
      next_st.first = 1'b1;
      next_st.rd = 1'b0;
      next_st.seen = 1'b1;
    end else if (!st.p_scl && scl) begin
      if (st.cnt < 4'h8 || st.cnt == 4'h9) begin
        next_st.sh = {st.sh[6:0], sda};
      end
      if (st.cnt == 4'h7 && st.first) begin
        next_st.rd = sda;
      end
      next_st.cnt = (st.cnt == 4'h9) ? 4'h1 : st.cnt + 4'h1;
      if (st.cnt == 4'h9) begin
        next_st.first = 1'b0;
      end
    end
    next_st.p_scl = scl;
    next_st.p_sda = sda;
  end
  always_ff @(posedge clock) begin
    st <= next_st;
  end
  assign hi = scl && st.p_scl;
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  sequence ack_slot_s;
    hi && st.cnt == 4'h9;
  endsequence
  sequence ack_end_s;
    $fell(scl) && st.cnt == 4'h9 && !st.rd;
  endsequence
  rst_release_a: assert property ($fell(srst) |-> s_sda_oe_n && m_sda_oe_n && scl_oe_n)
    else $error("A line is driven right after reset.");
  slave_change_low_a: assert property ($changed(s_sda_oe_n) |-> !scl)
    else $error("Slave moved data while clock high.");
  quiet_before_start_a: assert property (!st.seen |-> s_sda_oe_n)
    else $error("Slave drove data before any start.");
  id_match_a: assert property (ack_slot_s ##0 st.first |->
    (!s_sda_oe_n) == (st.sh[7:1] == {4'ha, addr_select}))
    else $error("Slave ack does not follow id match.");
  write_ack_slot_a: assert property (hi && !s_sda_oe_n && !st.rd |-> st.cnt == 4'h9)
    else $error("Slave pulled data outside the ack slot.");
  master_release_a: assert property (ack_slot_s ##0 (st.first || !st.rd) |-> m_sda_oe_n)
    else $error("Master held data during slave ack.");
  read_nack_a: assert property (ack_slot_s ##0 (st.rd && !st.first) |-> sda)
    else $error("Final read byte was acknowledged.");
  ack_release_a: assert property (ack_end_s |-> ##[1:8] s_sda_oe_n)
    else $error("Slave did not release data after ack.");
endmodule

/* File: verification/quad_pot_i2c_register_slave_tb.sv */
// Testbench joining the potentiometer slave and its master over the two-wire link.
`timescale 1ns/1ps
module quad_pot_i2c_register_slave_tb;
  import qpi_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [2:0] cmd_dev = 3'h5;
  logic [7:0] cmd_addr = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic [2:0] addr_select = 3'h5;
  logic cmd_ready, rsp_valid, rsp_nack, shutdown_n_bit, busy;
  logic [7:0] rsp_rdata;
  logic [7:0] wiper_position_reg [QPI_NUM_WIPERS];
  int n_mismatch = 0;
  int cmp_count = 0;
  always #10 clock = ~clock;
  qpi_bus_if bus_if ();
  qpi_slave qpi_slave_inst (.clock(clock), .srst(srst), .bus(bus_if), .addr_select(addr_select),
    .wiper_position_reg(wiper_position_reg), .shutdown_n_bit(shutdown_n_bit), .busy(busy));
  qpi_master qpi_master_inst (.clock(clock), .srst(srst), .bus(bus_if), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_dev(cmd_dev), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rsp_rdata(rsp_rdata), .rsp_valid(rsp_valid), .rsp_nack(rsp_nack));
  qpi_link_asserts qpi_link_asserts_inst (.clock(clock), .srst(srst), .scl(bus_if.scl), .sda(bus_if.sda),
    .scl_oe_n(bus_if.scl_oe_n), .m_sda_oe_n(bus_if.m_sda_oe_n), .s_sda_oe_n(bus_if.s_sda_oe_n),
    .addr_select(addr_select));
  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("Counts: %0d mismatches in %0d comparisons", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // The request is held until a rising edge sees ready, then dropped on the next falling edge.
  task automatic do_cmd(input logic rd, input logic [2:0] dev, input logic [7:0] addr, input logic [7:0] wd);
    int i;
    @(negedge clock);
    cmd_read = rd;
    cmd_dev = dev;
    cmd_addr = addr;
    cmd_wdata = wd;
    cmd_valid = 1'b1;
    i = 0;
    while (cmd_ready !== 1'b1 && i < 100) begin
      @(negedge clock);
      i++;
    end
    @(negedge clock);
    cmd_valid = 1'b0;
    check(cmd_ready, 1'b0);
    i = 0;
    while (rsp_valid !== 1'b1 && i < 5000) begin
      @(negedge clock);
      i++;
    end
    check(rsp_valid, 1'b1);
    i = 0;
    while (busy !== 1'b0 && i < 50) begin
      @(negedge clock);
      i++;
    end
    check(busy, 1'b0);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    for (int k = 0; k < 4; k++) check(wiper_position_reg[k], 8'h80);
    check(shutdown_n_bit, 1'b1);
    do_cmd(1'b1, 3'h5, 8'h10, 8'h00);
    check(rsp_rdata, 8'h40);
  endtask
  task automatic t_write_read;
    for (int k = 0; k < 4; k++) begin
      do_cmd(1'b0, 3'h5, 8'(k), 8'h5a + 8'(8'h21 * k));
      check(rsp_nack, 1'b0);
      check(wiper_position_reg[k], 8'h5a + 8'(8'h21 * k));
    end
    for (int k = 3; k >= 0; k--) begin
      do_cmd(1'b1, 3'h5, 8'(k), 8'h00);
      check(rsp_nack, 1'b0);
      check(rsp_rdata, 8'h5a + 8'(8'h21 * k));
    end
  endtask
  task automatic t_shutdown;
    do_cmd(1'b0, 3'h5, 8'h10, 8'h00);
    check(shutdown_n_bit, 1'b0);
    check(wiper_position_reg[2], 8'h9c);
    do_cmd(1'b1, 3'h5, 8'h10, 8'h00);
    check(rsp_rdata, 8'h00);
    do_cmd(1'b0, 3'h5, 8'h10, 8'hff);
    check(shutdown_n_bit, 1'b1);
    do_cmd(1'b1, 3'h5, 8'h10, 8'h00);
    check(rsp_rdata, 8'h40);
    do_cmd(1'b0, 3'h5, 8'h05, 8'hff);
    check(wiper_position_reg[0], 8'h5a);
  endtask
  // A stranger's id must leave the slave waiting for the next start only.
  task automatic t_wrong_dev;
    do_cmd(1'b0, 3'h4, 8'h00, 8'h11);
    check(rsp_nack, 1'b1);
    check(wiper_position_reg[0], 8'h5a);
    do_cmd(1'b0, 3'h5, 8'h03, 8'h01);
    check(rsp_nack, 1'b0);
    check(wiper_position_reg[3], 8'h01);
  endtask
  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (5) @(negedge clock);
    srst = 1'b0;
    repeat (12) @(negedge clock);
    t_reset();
    t_write_read();
    t_shutdown();
    t_wrong_dev();
    srst = 1'b1;
    repeat (5) @(negedge clock);
    srst = 1'b0;
    repeat (12) @(negedge clock);
    t_reset();
    tally_and_finish();
  end
  initial begin
    repeat (60000) @(posedge clock);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
